// file: common/dpm_map_if.sv
// carrier between the register bank and the frame classifier
interface dpm_map_if import dpm_pkg::*; ();
  logic [DPM_NUM_PAIRS-1:0][7:0] pair_map;
  logic igmp_en;
  logic mld_en;
  logic mld_opt;
  logic frame_valid;
  logic [5:0] frame_dscp;
  logic frame_is_ip;
  logic frame_is_ipv6;
  logic frame_is_igmp;
  logic [7:0] frame_next_hdr;
  logic [7:0] frame_hop_next_hdr;
  logic cls_valid;
  logic [DPM_PRIO_W-1:0] cls_prio;
  logic cls_dscp_hit;
  logic cls_to_host;
  modport regs (
    output pair_map, igmp_en, mld_en, mld_opt,
    output frame_valid, frame_dscp, frame_is_ip, frame_is_ipv6, frame_is_igmp,
    output frame_next_hdr, frame_hop_next_hdr,
    input cls_valid, cls_prio, cls_dscp_hit, cls_to_host
  );
  modport cls (
    input pair_map, igmp_en, mld_en, mld_opt,
    input frame_valid, frame_dscp, frame_is_ip, frame_is_ipv6, frame_is_igmp,
    input frame_next_hdr, frame_hop_next_hdr,
    output cls_valid, cls_prio, cls_dscp_hit, cls_to_host
  );
endinterface : dpm_map_if

// file: common/dpm_pkg.sv
// constants and types for the dscp priority map (codes 0x20..0x3b) and snoop control
// Functional notes
// - each map register is 8 bits, fields at bits 6:4 and 2:0.
// - register 0x0350 maps code 0x20 low field and 0x21 high field.
// - register 0x0351 maps code 0x22 low field and 0x23 high field.
// - register 0x0352 maps code 0x24 low field and 0x25 high field.
// - register 0x0353 maps code 0x26 low field and 0x27 high field.
// - register 0x0354 maps code 0x28 low field and 0x29 high field.
// - register 0x0355 maps code 0x2A low field and 0x2B high field.
// - codes 0x2C/0x2D pair, printed at colliding 0x0350, placed at 0x0356.
// - register 0x0357 maps code 0x2E low field and 0x2F high field.
// - register 0x0358 maps code 0x30 low field and 0x31 high field.
// - register 0x0359 maps code 0x32 low field and 0x33 high field.
// - register 0x035A maps code 0x34 low field and 0x35 high field.
// - register 0x035B maps code 0x36 low field and 0x37 high field.
// - register 0x035C maps code 0x38 low field and 0x39 high field.
// - register 0x035D maps code 0x3A low field and 0x3B high field.
// - enabled igmp or mld snooping sends those packets to the host port.
package dpm_pkg;
  localparam int unsigned DPM_NUM_PAIRS = 14;
  localparam int unsigned DPM_IDX_W = 10;
  localparam int unsigned DPM_ADDR_W = 12;
  localparam int unsigned DPM_PRIO_W = 3;
  localparam int unsigned DPM_HI_LSB = 4;
  localparam int unsigned DPM_LO_LSB = 0;
  localparam logic [7:0] DPM_PAIR_RW_MASK = 8'h77;
  localparam logic [7:0] DPM_PAIR_RESET = 8'h00;
  localparam logic [5:0] DPM_DSCP_FIRST = 6'h20;
  localparam logic [5:0] DPM_DSCP_LAST = 6'h3B;
  // register indices; byte address is four times the index
  localparam logic [DPM_IDX_W-1:0] DPM_PAIR_IDX [DPM_NUM_PAIRS] = '{
    10'h350, 10'h351, 10'h352, 10'h353, 10'h354, 10'h355,
    10'h356, // 0x0350 would alias the 0x20/0x21 pair
    10'h357, 10'h358, 10'h359, 10'h35A, 10'h35B, 10'h35C, 10'h35D};
  localparam logic [DPM_IDX_W-1:0] DPM_SNOOP_IDX = 10'h370;
  localparam logic [DPM_IDX_W-1:0] DPM_LOOKUP_CNT_IDX = 10'h3A0;
  localparam logic [DPM_IDX_W-1:0] DPM_HOST_CNT_IDX = 10'h3A1;
  // snoop control fields
  localparam int unsigned DPM_SNOOP_IGMP_EN_BIT = 6;
  localparam int unsigned DPM_SNOOP_MLD_OPT_BIT = 3;
  localparam int unsigned DPM_SNOOP_MLD_EN_BIT = 2;
  localparam int unsigned DPM_SNOOP_SNIFF_AND_BIT = 0;
  localparam logic [7:0] DPM_SNOOP_RW_MASK = 8'h4D;
  localparam logic [7:0] DPM_SNOOP_RESET = 8'h00;
  // ipv6 next header codes for mld matching
  localparam logic [7:0] DPM_NH_HOP_BY_HOP = 8'h00;
  localparam logic [7:0] DPM_NH_ICMP4 = 8'h01;
  localparam logic [7:0] DPM_NH_ICMP6 = 8'h3A;
  localparam logic [7:0] DPM_NH_ROUTING = 8'h2B;
  localparam logic [7:0] DPM_NH_FRAGMENT = 8'h2C;
  localparam logic [7:0] DPM_NH_ESP = 8'h32;
  localparam logic [7:0] DPM_NH_AUTH = 8'h33;
  localparam logic [7:0] DPM_NH_DEST_OPT = 8'h3C;
  // avalon response codes
  localparam logic [1:0] DPM_RESP_OKAY = 2'h0;
  localparam logic [1:0] DPM_RESP_DECODEERROR = 2'h3;
  typedef enum logic {
    DPM_BUS_IDLE = 1'b0,
    DPM_BUS_ANSWER = 1'b1
  } dpm_bus_state_t;
endpackage : dpm_pkg

// file: rtl/dpm_classifier.sv
// per-frame priority lookup and snoop-to-host decision
module dpm_classifier import dpm_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // map and frame fields
  dpm_map_if.cls map
);
  logic [5:0] dscp_off;
  logic [3:0] pair_sel;
  logic in_range;
  logic [7:0] pair_val;
  logic [DPM_PRIO_W-1:0] field;
  logic mld_hit;
  logic to_host;

  function automatic logic mld_code(input logic [7:0] nh, input logic opt);
    if (opt) begin
      mld_code = (nh == DPM_NH_ROUTING) || (nh == DPM_NH_FRAGMENT) || (nh == DPM_NH_ESP) ||
                 (nh == DPM_NH_AUTH) || (nh == DPM_NH_DEST_OPT);
    end else begin
      mld_code = (nh == DPM_NH_ICMP4) || (nh == DPM_NH_ICMP6);
    end
  endfunction : mld_code

  always_comb begin
    dscp_off = map.frame_dscp - DPM_DSCP_FIRST;
    pair_sel = dscp_off[4:1];
    in_range = map.frame_is_ip && (map.frame_dscp >= DPM_DSCP_FIRST) && (map.frame_dscp <= DPM_DSCP_LAST);
    pair_val = in_range ? map.pair_map[pair_sel] : 8'h00;
    // even code in the low field, odd code in the high field
    field = dscp_off[0] ? pair_val[DPM_HI_LSB +: DPM_PRIO_W] : pair_val[DPM_LO_LSB +: DPM_PRIO_W];
  end

  always_comb begin
    mld_hit = map.frame_is_ipv6 &&
              (mld_code(map.frame_next_hdr, map.mld_opt) ||
               ((map.frame_next_hdr == DPM_NH_HOP_BY_HOP) && mld_code(map.frame_hop_next_hdr, map.mld_opt)));
    to_host = (map.igmp_en && map.frame_is_igmp) || (map.mld_en && mld_hit);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      map.cls_valid <= 1'b0;
    end else begin
      map.cls_valid <= map.frame_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      map.cls_prio <= '0;
      map.cls_dscp_hit <= 1'b0;
      map.cls_to_host <= 1'b0;
    end else if (map.frame_valid) begin
      map.cls_prio <= field;
      map.cls_dscp_hit <= in_range;
      map.cls_to_host <= to_host;
    end
  end
endmodule : dpm_classifier

// file: rtl/dpm_dscp_prio_map.sv
// avalon-mm register bank for the upper dscp priority map with classifier
//
// Local design decision: the Avalon-MM interface to the registers.
module dpm_dscp_prio_map import dpm_pkg::*; #(
  parameter int unsigned ADDR_W = DPM_ADDR_W,
  parameter int unsigned CNT_W = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // avalon-mm slave, byte addressed
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  // frame fields from the parser
  input wire logic frame_valid,
  input wire logic [5:0] frame_dscp,
  input wire logic frame_is_ip,
  input wire logic frame_is_ipv6,
  input wire logic frame_is_igmp,
  input wire logic [7:0] frame_next_hdr,
  input wire logic [7:0] frame_hop_next_hdr,
  // classification result
  output logic cls_valid,
  output logic [DPM_PRIO_W-1:0] cls_prio,
  output logic cls_dscp_hit,
  output logic cls_to_host,
  // mirroring filter select
  output logic sniff_and_mode
);
  if (ADDR_W < DPM_ADDR_W || ADDR_W > 32) begin : g_addr_chk
    $error("ADDR_W must lie between 12 and 32");
  end
  if (CNT_W < 1 || CNT_W > 32) begin : g_cnt_chk
    $error("CNT_W must lie between 1 and 32");
  end

  dpm_map_if map ();

  dpm_bus_state_t state_reg;
  dpm_bus_state_t state_next;
  logic [7:0] pair_reg [DPM_NUM_PAIRS];
  logic [7:0] snoop_reg;
  logic [CNT_W-1:0] lookup_cnt_reg;
  logic [CNT_W-1:0] lookup_cnt_next;
  logic [CNT_W-1:0] host_cnt_reg;
  logic [CNT_W-1:0] host_cnt_next;
  logic [31:0] readdata_reg;
  logic [1:0] response_reg;

  logic req;
  logic take;
  logic [DPM_IDX_W-1:0] word_idx;
  logic high_zero;
  logic aligned;
  logic [DPM_NUM_PAIRS-1:0] pair_hit;
  logic snoop_hit;
  logic lookup_cnt_hit;
  logic host_cnt_hit;
  logic mapped;
  logic wr_en;
  logic [31:0] rd_mux;

  // address bits above the map must be zero
  if (ADDR_W > DPM_ADDR_W) begin : g_high
    assign high_zero = (avs_address[ADDR_W-1:DPM_ADDR_W] == '0);
  end else begin : g_no_high
    assign high_zero = 1'b1;
  end

  // address decode
  always_comb begin
    word_idx = avs_address[DPM_IDX_W+1:2];
    aligned = (avs_address[1:0] == 2'h0) && high_zero;
    snoop_hit = aligned && (word_idx == DPM_SNOOP_IDX);
    lookup_cnt_hit = aligned && (word_idx == DPM_LOOKUP_CNT_IDX);
    host_cnt_hit = aligned && (word_idx == DPM_HOST_CNT_IDX);
  end

  for (genvar i = 0; i < DPM_NUM_PAIRS; i++) begin : g_pair_dec
    assign pair_hit[i] = aligned && (word_idx == DPM_PAIR_IDX[i]);
  end

  assign mapped = (|pair_hit) || snoop_hit || lookup_cnt_hit || host_cnt_hit;

  // one wait state: answer on the cycle after the request appears
  assign req = avs_read ^ avs_write;
  assign take = req && (state_reg == DPM_BUS_ANSWER);
  assign wr_en = take && avs_write && avs_byteenable[0];
  assign avs_waitrequest = req && (state_reg == DPM_BUS_IDLE);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DPM_BUS_IDLE: begin
        if (req) begin
          state_next = DPM_BUS_ANSWER;
        end
      end
      DPM_BUS_ANSWER: begin
        state_next = DPM_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= DPM_BUS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // read mux, captured while waitrequest is high
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int j = 0; j < DPM_NUM_PAIRS; j++) begin
      if (pair_hit[j]) begin
        rd_mux = {24'h00_0000, pair_reg[j] & DPM_PAIR_RW_MASK};
      end
    end
    if (snoop_hit) begin
      rd_mux = {24'h00_0000, snoop_reg & DPM_SNOOP_RW_MASK};
    end
    if (lookup_cnt_hit) begin
      rd_mux = 32'(lookup_cnt_reg);
    end
    if (host_cnt_hit) begin
      rd_mux = 32'(host_cnt_reg);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      readdata_reg <= 32'h0000_0000;
      response_reg <= DPM_RESP_OKAY;
    end else if (req && state_reg == DPM_BUS_IDLE) begin
      readdata_reg <= avs_read ? rd_mux : 32'h0000_0000;
      response_reg <= mapped ? DPM_RESP_OKAY : DPM_RESP_DECODEERROR;
    end
  end

  assign avs_readdata = readdata_reg;
  assign avs_response = response_reg;

  // map registers, priority fields only
  for (genvar i = 0; i < DPM_NUM_PAIRS; i++) begin : g_pair_reg
    always_ff @(posedge clock) begin
      if (reset) begin
        pair_reg[i] <= DPM_PAIR_RESET;
      end else if (wr_en && pair_hit[i]) begin
        pair_reg[i] <= avs_writedata[7:0] & DPM_PAIR_RW_MASK;
      end
    end
    // pair i covers codes 0x20+2i (low) and 0x21+2i (high)
    assign map.pair_map[i] = pair_reg[i];
  end

  // snoop and mirroring control
  always_ff @(posedge clock) begin
    if (reset) begin
      snoop_reg <= DPM_SNOOP_RESET;
    end else if (wr_en && snoop_hit) begin
      snoop_reg <= avs_writedata[7:0] & DPM_SNOOP_RW_MASK;
    end
  end

  assign map.igmp_en = snoop_reg[DPM_SNOOP_IGMP_EN_BIT];
  assign map.mld_en = snoop_reg[DPM_SNOOP_MLD_EN_BIT];
  assign map.mld_opt = snoop_reg[DPM_SNOOP_MLD_OPT_BIT];
  assign sniff_and_mode = snoop_reg[DPM_SNOOP_SNIFF_AND_BIT];

  // counters; a write clears, a same-cycle event still counts
  always_comb begin
    lookup_cnt_next = lookup_cnt_reg + CNT_W'(map.cls_valid && map.cls_dscp_hit);
    if (wr_en && lookup_cnt_hit) begin
      lookup_cnt_next = CNT_W'(map.cls_valid && map.cls_dscp_hit);
    end
    host_cnt_next = host_cnt_reg + CNT_W'(map.cls_valid && map.cls_to_host);
    if (wr_en && host_cnt_hit) begin
      host_cnt_next = CNT_W'(map.cls_valid && map.cls_to_host);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      lookup_cnt_reg <= '0;
      host_cnt_reg <= '0;
    end else begin
      lookup_cnt_reg <= lookup_cnt_next;
      host_cnt_reg <= host_cnt_next;
    end
  end

  // frame path into the classifier
  assign map.frame_valid = frame_valid;
  assign map.frame_dscp = frame_dscp;
  assign map.frame_is_ip = frame_is_ip;
  assign map.frame_is_ipv6 = frame_is_ipv6;
  assign map.frame_is_igmp = frame_is_igmp;
  assign map.frame_next_hdr = frame_next_hdr;
  assign map.frame_hop_next_hdr = frame_hop_next_hdr;

  dpm_classifier u_classifier (
    .clock(clock),
    .reset(reset),
    .map(map.cls)
  );

  assign cls_valid = map.cls_valid;
  assign cls_prio = map.cls_prio;
  assign cls_dscp_hit = map.cls_dscp_hit;
  assign cls_to_host = map.cls_to_host;
endmodule : dpm_dscp_prio_map

// file: sim/dpm_dscp_prio_map_sva.sv
// assertions on the dscp priority map ports
module dpm_dscp_prio_map_sva import dpm_pkg::*; #(
  parameter int unsigned ADDR_W = DPM_ADDR_W,
  parameter int unsigned CNT_W = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0] avs_response,
  input wire logic avs_waitrequest,
  // frame path
  input wire logic frame_valid,
  input wire logic [5:0] frame_dscp,
  input wire logic frame_is_ip,
  input wire logic cls_valid,
  input wire logic [DPM_PRIO_W-1:0] cls_prio,
  input wire logic cls_dscp_hit,
  input wire logic cls_to_host
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic in_range;
  logic pair_ans;
  assign in_range = frame_is_ip && frame_dscp >= DPM_DSCP_FIRST && frame_dscp <= DPM_DSCP_LAST;
  assign pair_ans = avs_address[1:0] == 2'h0 && avs_address[11:2] >= 10'h350 && avs_address[11:2] <= 10'h35D;
  sequence s_req_wait;
    (avs_read ^ avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    (avs_read ^ avs_write) && !avs_waitrequest;
  endsequence
  chk_one_wait: assert property (s_req_wait |=> s_ans) else $error("no answer after one wait state");
  chk_idle_ready: assert property (!(avs_read ^ avs_write) |-> !avs_waitrequest) else $error("wait without request");
  chk_pair_okay: assert property (s_ans and pair_ans |-> avs_response == DPM_RESP_OKAY)
    else $error("map register not okay");
  chk_misalign_err: assert property (s_ans and avs_address[1:0] != 2'h0 |-> avs_response == DPM_RESP_DECODEERROR)
    else $error("misaligned access accepted");
  chk_resv_zero: assert property (avs_read && !avs_waitrequest && pair_ans |-> avs_readdata[31:7] == 25'h0
    && !avs_readdata[3]) else $error("reserved bits not zero");
  chk_cls_delay: assert property (frame_valid |=> cls_valid) else $error("result not one cycle after frame");
  chk_cls_pulse: assert property (!frame_valid |=> !cls_valid) else $error("result without frame");
  chk_hit_calc: assert property (frame_valid |=> cls_dscp_hit == $past(in_range))
    else $error("dscp hit wrong");
  chk_miss_zero: assert property (frame_valid && !in_range |=> cls_prio == 3'h0) else $error("priority on miss");
  chk_prio_hold: assert property (!frame_valid |=> $stable(cls_prio) && $stable(cls_to_host))
    else $error("result changed without frame");
endmodule : dpm_dscp_prio_map_sva

bind dpm_dscp_prio_map dpm_dscp_prio_map_sva #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) dpm_dscp_prio_map_sva_i (
  .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
  .frame_valid(frame_valid), .frame_dscp(frame_dscp), .frame_is_ip(frame_is_ip), .cls_valid(cls_valid),
  .cls_prio(cls_prio), .cls_dscp_hit(cls_dscp_hit), .cls_to_host(cls_to_host));

// file: sim/test_dpm_dscp_prio_map.sv
// self-checking bench for the dscp priority map
module test_dpm_dscp_prio_map import dpm_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, frame_valid = 1'b0;
  logic frame_is_ip = 1'b0, frame_is_ipv6 = 1'b0, frame_is_igmp = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [5:0] frame_dscp = 6'h00;
  logic [7:0] frame_next_hdr = 8'h00, frame_hop_next_hdr = 8'h00;
  logic [1:0] avs_response;
  logic avs_waitrequest, cls_valid, cls_dscp_hit, cls_to_host, sniff_and_mode;
  logic [2:0] cls_prio;
  logic [7:0] mp [14];
  logic [33:0] rd_q [$];
  logic [33:0] cl_q [$];
  int seed = 6;
  int miscompares = 0;
  int comparisons = 0;
  dpm_dscp_prio_map dpm_dscp_prio_map_i (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
    .frame_valid(frame_valid), .frame_dscp(frame_dscp), .frame_is_ip(frame_is_ip), .frame_is_ipv6(frame_is_ipv6),
    .frame_is_igmp(frame_is_igmp), .frame_next_hdr(frame_next_hdr), .frame_hop_next_hdr(frame_hop_next_hdr),
    .cls_valid(cls_valid), .cls_prio(cls_prio), .cls_dscp_hit(cls_dscp_hit), .cls_to_host(cls_to_host),
    .sniff_and_mode(sniff_and_mode));
  always #5 clock = ~clock;
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    comparisons++;
    if (e !== s) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tally_and_finish;
    chk("leftover", 34'h0, 34'(rd_q.size() + cl_q.size()));
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // one avalon access; a read notes its expected response and data
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [33:0] e);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {d, d, d, d};
    avs_write <= wr;
    avs_read <= !wr;
    if (!wr) rd_q.push_back(e);
    // hold until waitrequest is sampled low at a rising edge
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  function automatic logic [33:0] exp_cls(input logic [5:0] ds, input logic ip, input logic host);
    logic [7:0] r;
    if (!ip || ds < 6'h20 || ds > 6'h3B) return {29'h0, host, 4'h0};
    r = mp[(ds - 6'h20) >> 1];
    return {29'h0, host, 1'b1, ds[0] ? r[6:4] : r[2:0]};
  endfunction : exp_cls
  // frames go back to back; caller lowers frame_valid afterwards
  task automatic frm(input logic [5:0] ds, input logic ip, v6, ig, input logic [7:0] nh, hop, input logic host);
    @(posedge clock);
    frame_valid <= 1'b1;
    frame_dscp <= ds;
    frame_is_ip <= ip;
    frame_is_ipv6 <= v6;
    frame_is_igmp <= ig;
    frame_next_hdr <= nh;
    frame_hop_next_hdr <= hop;
    cl_q.push_back(exp_cls(ds, ip, host));
  endtask : frm
  always @(negedge clock) begin
    if (avs_read && avs_waitrequest === 1'b0) chk("readdata", rd_q.size() ? rd_q.pop_front() : 'x,
      {avs_response, avs_readdata});
    if (cls_valid !== 1'b0) chk("classify", cl_q.size() ? cl_q.pop_front() : 'x,
      {29'h0, cls_to_host, cls_dscp_hit, cls_prio});
  end
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    int i;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    for (i = 0; i < 14; i++) bus(1'b0, 12'hD40 + 12'(4 * i), 8'h00, 34'h0);
    $display("test reset values done");
    for (i = 0; i < 14; i++) begin
      mp[i] = 8'($random(seed));
      bus(1'b1, 12'hD40 + 12'(4 * i), mp[i], 34'h0);
      mp[i] = mp[i] & DPM_PAIR_RW_MASK;
    end
    for (i = 0; i < 14; i++) bus(1'b0, 12'hD40 + 12'(4 * i), 8'h00, {26'h0, mp[i]});
    $display("test map write and read done");
    for (i = 6'h1F; i < 6'h2E; i++) frm(6'(i), 1'b1, 1'b0, 1'b0, 8'h06, 8'h06, 1'b0);
    for (i = 6'h2E; i < 6'h3D; i++) frm(6'(i), 1'b1, 1'b1, 1'b0, 8'h06, 8'h06, 1'b0);
    frm(6'h21, 1'b0, 1'b0, 1'b0, 8'h06, 8'h06, 1'b0);
    @(posedge clock);
    frame_valid <= 1'b0;
    $display("test dscp lookup done");
    bus(1'b0, 12'hE80, 8'h00, 34'h1C);
    bus(1'b1, 12'hE80, 8'h5A, 34'h0);
    bus(1'b0, 12'hE80, 8'h00, 34'h0);
    bus(1'b0, 12'hD78, 8'h00, {DPM_RESP_DECODEERROR, 32'h0});
    bus(1'b1, 12'hD41, 8'h77, 34'h0);
    avs_byteenable <= 4'h0;
    bus(1'b1, 12'hD40, 8'h77, 34'h0);
    avs_byteenable <= 4'hF;
    bus(1'b0, 12'hD40, 8'h00, {26'h0, mp[0]});
    $display("test refused access done");
    bus(1'b1, 12'hDC0, 8'hFF, 34'h0);
    bus(1'b0, 12'hDC0, 8'h00, 34'h4D);
    chk("sniff", 34'h1, 34'(sniff_and_mode));
    frm(6'h00, 1'b1, 1'b0, 1'b1, 8'h02, 8'h00, 1'b1);
    frm(6'h2C, 1'b1, 1'b1, 1'b0, 8'h2B, 8'h00, 1'b1);
    frm(6'h2D, 1'b1, 1'b1, 1'b0, 8'h00, 8'h3C, 1'b1);
    frm(6'h05, 1'b1, 1'b1, 1'b0, 8'h3A, 8'h00, 1'b0);
    @(posedge clock);
    frame_valid <= 1'b0;
    bus(1'b1, 12'hDC0, 8'h04, 34'h0);
    frm(6'h3B, 1'b1, 1'b1, 1'b0, 8'h3A, 8'h00, 1'b1);
    frm(6'h20, 1'b1, 1'b1, 1'b0, 8'h00, 8'h01, 1'b1);
    frm(6'h00, 1'b1, 1'b0, 1'b1, 8'h02, 8'h00, 1'b0);
    @(posedge clock);
    frame_valid <= 1'b0;
    chk("sniff", 34'h0, 34'(sniff_and_mode));
    bus(1'b0, 12'hE80, 8'h00, 34'h4);
    bus(1'b0, 12'hE84, 8'h00, 34'h5);
    $display("test snooping done");
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    bus(1'b0, 12'hD58, 8'h00, 34'h0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : test_dpm_dscp_prio_map
